// ===== hdl/kpio_defs.vh
// kpio_defs.vh: register map, field positions and reset values for the keypad/peripheral/display port block
// assumes: included by kpio_ports.v, the property checker and the bench; addresses are word indices on the avalon-mm slave
`ifndef KPIO_DEFS_VH
`define KPIO_DEFS_VH

// register indices (byte address = index * 4)
`define KPIO_IDX_KEYPAD_DATA     9'h006
`define KPIO_IDX_PERIPH_DATA     9'h007
`define KPIO_IDX_DISPLAY_DATA    9'h008
`define KPIO_IDX_OPTION          9'h081
`define KPIO_IDX_KEYPAD_DIR      9'h086
`define KPIO_IDX_PERIPH_DIR      9'h087
`define KPIO_IDX_DISPLAY_DIR     9'h088
`define KPIO_IDX_INTCTRL         9'h00B
`define KPIO_IDX_SEGEN           9'h10D
`define KPIO_IDX_PERIPH_OVR      9'h190
`define KPIO_IDX_MODE            9'h191

// field positions
`define KPIO_OPT_PULLUP_N_BIT    7
`define KPIO_INT_CHANGE_BIT      0
`define KPIO_INT_EXT_BIT         1
`define KPIO_SEG_LOW_BIT         0
`define KPIO_SEG_HIGH_BIT        7
`define KPIO_MODE_EXTINT_BIT     0
`define KPIO_MODE_SERPROG_BIT    1

// reset values
`define KPIO_RST_OPTION          8'hFF
`define KPIO_RST_KEYPAD_DIR      8'hFF
`define KPIO_RST_PERIPH_DIR      6'h3F
`define KPIO_RST_DISPLAY_DIR     8'hFF
`define KPIO_RST_SEGEN           8'hFF
`define KPIO_RST_DISPLAY_DATA    8'h00
`define KPIO_RST_ZERO8           8'h00

`endif

// ===== hdl/kpio_ports.v
// kpio_ports.v: three-port gpio block (keypad, peripheral, display) with an avalon-mm register slave
// assumes: one 125 MHz clock, pins already synchronous, lcd and peripheral engines live outside
//
// Summary of operation
// - clearing pullup_enable_n turns on all keypad pull-ups
// - output-configured keypad pins lose their pull-up
// - pull-ups off after reset until software enables
// - only upper four input pins detect change
// - compare inputs against latch from last read
// - ORed mismatches set change flag, bit 0
// - change flag can wake device from sleep
// - keypad data read or write reloads latch
// - persisting mismatch keeps setting the change flag
// - keypad bit 0 is external interrupt input
// - keypad bits 6,7 are serial programming pins
// - peripheral port six bits, per-pin direction
// - enabled peripheral overrides peripheral pin direction
// - peripheral bit2 ccp, bits 3-5 serial port
// - display low five gpio/segment, upper three input (segen bit 7 also hands them to the lcd)
// - display direction governs only lower five pins
// - display pins reset to segment drivers
// - segment enable overrides display direction bits
// - direction set means hi-z, clear drives latch
`include "kpio_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module kpio_ports #(
    parameter KP_W = 8,                           // keypad port width
    parameter PP_W = 6,                           // peripheral port width
    parameter DP_W = 8                            // display port width
) (
    input  wire            clock,                 // core clock, 125 MHz
    input  wire            reset_n,               // synchronous reset, active low
    input  wire [10:0]     avs_address,           // byte address
    input  wire            avs_read,              // read request
    input  wire            avs_write,             // write request
    input  wire [31:0]     avs_writedata,         // write data
    input  wire [3:0]      avs_byteenable,        // byte lanes, lane 0 carries the register
    output reg  [31:0]     avs_readdata,          // read data, registered
    output wire            avs_waitrequest,       // stall until answer stage
    input  wire [KP_W-1:0] kp_pin_in,             // keypad pin levels
    output reg  [KP_W-1:0] kp_pin_out,            // keypad output latch
    output reg  [KP_W-1:0] kp_pin_oe,             // keypad driver enables, high drives
    output reg  [KP_W-1:0] kp_pullup_en,          // weak pull-up enables per pin
    input  wire [PP_W-1:0] pp_pin_in,             // peripheral pin levels
    output reg  [PP_W-1:0] pp_pin_out,            // peripheral pin output value
    output reg  [PP_W-1:0] pp_pin_oe,             // peripheral driver enables
    input  wire [PP_W-1:0] pp_periph_out,         // peripheral-supplied output values
    output wire [PP_W-1:0] pp_periph_in,          // pin levels handed to peripherals
    input  wire [DP_W-1:0] dp_pin_in,             // display pin levels
    output reg  [DP_W-1:0] dp_pin_out,            // display output latch
    output reg  [DP_W-1:0] dp_pin_oe,             // display gpio driver enables
    output reg  [DP_W-1:0] dp_seg_drive,          // pins handed to the lcd driver
    output reg             ext_interrupt_pin,     // keypad bit 0 as external interrupt level
    output reg  [1:0]      serial_prog_pins,      // keypad bits 7:6 in programming mode
    output reg             port_change_irq,       // change flag level for the interrupt logic
    output reg             wake_request           // wake from sleep request
);

////////////////////////////////////////////////////////////////////////////////
// register state
reg  [7:0]      option_ff;                        // option_config, bit 7 is pullup_enable_n
reg  [KP_W-1:0] kp_latch_ff;                      // keypad_port_data output latch
reg  [KP_W-1:0] kp_dir_ff;                        // keypad_port_direction, 1 = input
reg  [PP_W-1:0] pp_latch_ff;                      // peripheral_port_data output latch
reg  [PP_W-1:0] pp_dir_ff;                        // peripheral_port_direction
reg  [DP_W-1:0] dp_latch_ff;                      // display port data latch
reg  [DP_W-1:0] dp_dir_ff;                        // display port direction
reg  [7:0]      segen_ff;                         // segment_enable_reg
reg  [1:0]      intctl_ff;                        // change flag and external flag
reg  [PP_W-1:0] pp_ovr_en_ff;                     // peripheral owns pin
reg  [PP_W-1:0] pp_ovr_dir_ff;                    // forced direction, 1 = input
reg  [1:0]      mode_ff;                          // ext interrupt and serial programming modes
reg  [3:0]      kp_old_ff;                        // comparison latch for pins 7:4
reg             kp0_prev_ff;                      // previous bit 0 level for edge detect
reg             ack_ff;                           // answer stage of a bus access
reg  [31:0]     nxt_readdata;                     // read mux
reg  [1:0]      nxt_intctl;                       // next interrupt flags
wire [8:0]      reg_idx;                          // word index from byte address
wire            wr_go;                            // write takes effect this edge
wire            rd_go;                            // read data taken this edge
wire            kp_access;                        // keypad data read or write
wire [3:0]      mismatch;                         // per-pin change detect
wire            seg_lo;                           // low display group on lcd
wire            seg_hi;                           // high display group on lcd
wire [PP_W-1:0] pp_dir_eff;                       // effective peripheral direction
integer         i;                                // loop index

assign reg_idx         = avs_address[10:2];
// one wait cycle per access: request seen, then answered on the next edge
assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
assign wr_go           = avs_write & ack_ff & avs_byteenable[0];
assign rd_go           = avs_read & ack_ff;
assign kp_access       = (wr_go | rd_go) & (reg_idx == `KPIO_IDX_KEYPAD_DATA);
assign seg_lo          = segen_ff[`KPIO_SEG_LOW_BIT];
assign seg_hi          = segen_ff[`KPIO_SEG_HIGH_BIT];
assign pp_dir_eff      = (pp_dir_ff & ~pp_ovr_en_ff) | (pp_ovr_dir_ff & pp_ovr_en_ff);
assign pp_periph_in    = pp_pin_in;
// input pins 7:4 only; outputs are masked out of the comparison
assign mismatch = (kp_pin_in[7:4] ^ kp_old_ff) & kp_dir_ff[7:4];

////////////////////////////////////////////////////////////////////////////////
// bus handshake stage
always @(posedge clock) begin
    if (!reset_n) begin
        ack_ff <= 1'b0;
    end else begin
        // drop after the answer edge so back-to-back requests each wait once
        ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, narrow registers sit in low bits
always @* begin
    nxt_readdata = 32'h00000000;
    case (reg_idx)
        `KPIO_IDX_KEYPAD_DATA:  nxt_readdata[KP_W-1:0] = kp_pin_in;    // pins, not latch
        `KPIO_IDX_PERIPH_DATA:  nxt_readdata[PP_W-1:0] = pp_pin_in;    // bits 7:6 read 0
        `KPIO_IDX_DISPLAY_DATA: nxt_readdata[DP_W-1:0] = dp_pin_in;
        `KPIO_IDX_OPTION:       nxt_readdata[7:0]      = option_ff;
        `KPIO_IDX_KEYPAD_DIR:   nxt_readdata[KP_W-1:0] = kp_dir_ff;
        `KPIO_IDX_PERIPH_DIR:   nxt_readdata[PP_W-1:0] = pp_dir_ff;
        `KPIO_IDX_DISPLAY_DIR:  nxt_readdata[DP_W-1:0] = dp_dir_ff;
        `KPIO_IDX_INTCTRL:      nxt_readdata[1:0]      = intctl_ff;
        `KPIO_IDX_SEGEN:        nxt_readdata[7:0]      = segen_ff;
        `KPIO_IDX_PERIPH_OVR:   nxt_readdata[15:0]     = {2'b00, pp_ovr_dir_ff, 2'b00, pp_ovr_en_ff};
        `KPIO_IDX_MODE:         nxt_readdata[1:0]      = mode_ff;
        default:                nxt_readdata           = 32'h00000000;  // unmapped reads zero
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// interrupt flags: hardware set beats software clear
always @* begin
    nxt_intctl = intctl_ff;
    if (wr_go && reg_idx == `KPIO_IDX_INTCTRL) begin
        nxt_intctl = avs_writedata[1:0];
    end
    // a persisting mismatch sets the flag again even right after a clear
    if (|mismatch) begin
        nxt_intctl[`KPIO_INT_CHANGE_BIT] = 1'b1;
    end
    if (mode_ff[`KPIO_MODE_EXTINT_BIT] && kp_pin_in[0] && !kp0_prev_ff && kp_dir_ff[0]) begin
        nxt_intctl[`KPIO_INT_EXT_BIT] = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes and comparison latch
always @(posedge clock) begin
    if (!reset_n) begin
        option_ff     <= `KPIO_RST_OPTION;
        kp_latch_ff   <= `KPIO_RST_ZERO8;
        kp_dir_ff     <= `KPIO_RST_KEYPAD_DIR;
        pp_latch_ff   <= 6'h00;
        pp_dir_ff     <= `KPIO_RST_PERIPH_DIR;
        dp_latch_ff   <= `KPIO_RST_DISPLAY_DATA;
        dp_dir_ff     <= `KPIO_RST_DISPLAY_DIR;
        segen_ff      <= `KPIO_RST_SEGEN;
        intctl_ff     <= 2'b00;
        pp_ovr_en_ff  <= 6'h00;
        pp_ovr_dir_ff <= 6'h00;
        mode_ff       <= 2'b00;
        kp_old_ff     <= 4'h0;
        kp0_prev_ff   <= 1'b0;
        avs_readdata  <= 32'h00000000;
    end else begin
        intctl_ff   <= nxt_intctl;
        kp0_prev_ff <= kp_pin_in[0];
        // capture read data on the answer edge only
        if (rd_go) begin
            avs_readdata <= nxt_readdata;
        end
        // any read or write of keypad data ends the mismatch
        if (kp_access) begin
            kp_old_ff <= kp_pin_in[7:4];
        end
        if (wr_go) begin
            case (reg_idx)
                `KPIO_IDX_KEYPAD_DATA:  kp_latch_ff   <= avs_writedata[KP_W-1:0];
                `KPIO_IDX_PERIPH_DATA:  pp_latch_ff   <= avs_writedata[PP_W-1:0];
                `KPIO_IDX_DISPLAY_DATA: dp_latch_ff   <= avs_writedata[DP_W-1:0];
                `KPIO_IDX_OPTION:       option_ff     <= avs_writedata[7:0];
                `KPIO_IDX_KEYPAD_DIR:   kp_dir_ff     <= avs_writedata[KP_W-1:0];
                `KPIO_IDX_PERIPH_DIR:   pp_dir_ff     <= avs_writedata[PP_W-1:0];
                `KPIO_IDX_DISPLAY_DIR:  dp_dir_ff     <= avs_writedata[DP_W-1:0];
                `KPIO_IDX_SEGEN:        segen_ff      <= avs_writedata[7:0];
                `KPIO_IDX_PERIPH_OVR: begin
                    pp_ovr_en_ff  <= avs_writedata[PP_W-1:0];
                    pp_ovr_dir_ff <= avs_writedata[PP_W+7:8];
                end
                `KPIO_IDX_MODE:         mode_ff       <= avs_writedata[1:0];
                default: begin
                    // unmapped writes are accepted and dropped
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin drivers, all registered
always @(posedge clock) begin
    if (!reset_n) begin
        kp_pin_out        <= 8'h00;
        kp_pin_oe         <= 8'h00;
        kp_pullup_en      <= 8'h00;
        pp_pin_out        <= 6'h00;
        pp_pin_oe         <= 6'h00;
        dp_pin_out        <= 8'h00;
        dp_pin_oe         <= 8'h00;
        dp_seg_drive      <= 8'hFF;
        ext_interrupt_pin <= 1'b0;
        serial_prog_pins  <= 2'b00;
        port_change_irq   <= 1'b0;
        wake_request      <= 1'b0;
    end else begin
        kp_pin_out <= kp_latch_ff;
        kp_pin_oe  <= ~kp_dir_ff;
        // global active-low enable, each output pin masked off
        for (i = 0; i < KP_W; i = i + 1) begin
            kp_pullup_en[i] <= ~option_ff[`KPIO_OPT_PULLUP_N_BIT] & kp_dir_ff[i];
        end
        // peripheral owns value and direction of the pins it claims
        pp_pin_out <= (pp_latch_ff & ~pp_ovr_en_ff) | (pp_periph_out & pp_ovr_en_ff);
        pp_pin_oe  <= ~pp_dir_eff;
        dp_pin_out <= dp_latch_ff;
        // upper three pins are never driven as gpio
        dp_pin_oe    <= {3'b000, ~dp_dir_ff[4:0] & {5{~seg_lo}}};
        dp_seg_drive <= {{3{seg_hi}}, {5{seg_lo}}};
        ext_interrupt_pin <= mode_ff[`KPIO_MODE_EXTINT_BIT] & kp_pin_in[0];
        serial_prog_pins  <= mode_ff[`KPIO_MODE_SERPROG_BIT] ? kp_pin_in[7:6] : 2'b00;
        port_change_irq   <= intctl_ff[`KPIO_INT_CHANGE_BIT];
        wake_request      <= intctl_ff[`KPIO_INT_CHANGE_BIT];
    end
end

endmodule // kpio_ports
`default_nettype wire

// ===== testbench/kpio_pin_model.sv
// kpio_pin_model.sv: keypad pins: keys short to ground, weak pull-ups, open lines wander
// assumes: fed from kpio_ports keypad outputs; key_down set by the bench
`timescale 1ns/100ps
`default_nettype none
module kpio_pin_model (
    input wire logic       clock,        // paces the floating pattern
    input wire logic [7:0] kp_pin_out,   // output latch
    input wire logic [7:0] kp_pin_oe,    // drivers
    input wire logic [7:0] kp_pullup_en, // weak pull-ups
    input wire logic [7:0] key_down,     // closed keys
    output logic [7:0]     kp_pin_in     // resolved levels
);
    logic [7:0] float_ff = 8'h00;        // open lines 0, 2, 5 and 7 toggle each clock; lines 1, 3, 4 and 6 stay low
    always @(posedge clock) begin
        float_ff <= ~float_ff ^ 8'h5A;
    end
    // driver wins, then a closed key, then the pull-up, else the line floats
    assign kp_pin_in = (kp_pin_oe & kp_pin_out) | (~kp_pin_oe & ~key_down & (kp_pullup_en | float_ff));
endmodule // kpio_pin_model
`default_nettype wire

// ===== testbench/kpio_ports_properties.sv
// kpio_ports_properties.sv: bus, pin and change-flag checks on kpio_ports
// assumes: one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "kpio_defs.vh"
module kpio_props #(parameter KP_W = 8, parameter DP_W = 8) (
    input wire logic            clock,             // core clock
    input wire logic            reset_n,           // reset, low active
    input wire logic [10:0]     avs_address,       // byte address
    input wire logic            avs_read,          // read
    input wire logic            avs_write,         // write
    input wire logic [31:0]     avs_writedata,     // write data
    input wire logic [3:0]      avs_byteenable,    // lanes
    input wire logic            avs_waitrequest,   // stall
    input wire logic [KP_W-1:0] kp_pin_in,         // keypad levels
    input wire logic [KP_W-1:0] kp_pin_oe,         // keypad drivers
    input wire logic [KP_W-1:0] kp_pullup_en,      // pull-ups
    input wire logic [DP_W-1:0] dp_pin_oe,         // display drivers
    input wire logic [DP_W-1:0] dp_seg_drive,      // lcd owns pin
    input wire logic            ext_interrupt_pin, // ext interrupt level
    input wire logic [1:0]      serial_prog_pins,  // programming pins
    input wire logic            port_change_irq,   // change flag
    input wire logic            wake_request       // wake
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!reset_n);
    // a taken clear write is the only way the flag may drop, two edges later
    wire clr_w = avs_write && !avs_waitrequest && avs_address[10:2] == `KPIO_IDX_INTCTRL
        && avs_byteenable[0] && !avs_writedata[0];
    pullup_out_a: assert property ((kp_pullup_en & kp_pin_oe) == '0) else $error("pull-up on a driven pin");
    reset_vals_a: assert property ($rose(reset_n) |-> kp_pullup_en == '0 && dp_seg_drive == '1 && !port_change_irq)
        else $error("outputs not at reset values");
    wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("not exactly one wait state");
    wake_follow_a: assert property (wake_request == port_change_irq) else $error("wake differs from flag");
    flag_hold_a: assert property ($fell(port_change_irq) |-> $past(clr_w, 2)) else $error("flag dropped early");
    ext_int_a: assert property (ext_interrupt_pin |-> $past(kp_pin_in[0])) else $error("ext level without pin");
    serprog_a: assert property (serial_prog_pins != 2'h0 |-> serial_prog_pins == $past(kp_pin_in[KP_W-1:KP_W-2]))
        else $error("programming pins differ");
    disp_oe_a: assert property (dp_pin_oe[DP_W-1:5] == '0 && (dp_pin_oe & dp_seg_drive) == '0)
        else $error("display driver enabled where not allowed");
    c_change: cover property ($rose(port_change_irq));
    c_prog: cover property (serial_prog_pins != 2'h0);
    c_split: cover property (dp_seg_drive == 8'h1F);
endmodule // kpio_props
bind kpio_ports kpio_props #(.KP_W(KP_W), .DP_W(DP_W)) u_props (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .kp_pin_in(kp_pin_in), .kp_pin_oe(kp_pin_oe), .kp_pullup_en(kp_pullup_en), .dp_pin_oe(dp_pin_oe),
    .dp_seg_drive(dp_seg_drive), .ext_interrupt_pin(ext_interrupt_pin), .serial_prog_pins(serial_prog_pins),
    .port_change_irq(port_change_irq), .wake_request(wake_request));
`default_nettype wire

// ===== testbench/tb_keypad_io_ports_b_c_d.sv
// tb_keypad_io_ports_b_c_d.sv: self-checking bench for the three-port block
// assumes: kpio_ports, kpio_pin_model and the bound checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "kpio_defs.vh"
module tb_keypad_io_ports_b_c_d;
    logic clock = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [10:0] avs_address = 11'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest, ext_interrupt_pin, port_change_irq, wake_request;
    // m is the checker's own mask copy, so the stimulus value in r is never overwritten by a compare
    logic [7:0] kp_pin_in, kp_pin_out, kp_pin_oe, kp_pullup_en, key_down = 8'h00, r, m, exp_q[$], msk_q[$];
    logic [5:0] pp_pin_in = 6'h00, pp_pin_out, pp_pin_oe, pp_periph_out = 6'h00, pp_periph_in;
    logic [7:0] dp_pin_in = 8'h00, dp_pin_out, dp_pin_oe, dp_seg_drive;
    logic [1:0] serial_prog_pins;
    logic [8:0] ridx[5] = '{`KPIO_IDX_OPTION, `KPIO_IDX_KEYPAD_DIR, `KPIO_IDX_PERIPH_DIR, `KPIO_IDX_SEGEN, 9'h1FF};
    logic [7:0] rval[5] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h00};
    integer n_fail = 0, checks_done = 0, seed = 39121, i;
    always #4 clock = ~clock;
    kpio_ports uut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .kp_pin_in(kp_pin_in),
        .kp_pin_out(kp_pin_out), .kp_pin_oe(kp_pin_oe), .kp_pullup_en(kp_pullup_en), .pp_pin_in(pp_pin_in),
        .pp_pin_out(pp_pin_out), .pp_pin_oe(pp_pin_oe), .pp_periph_out(pp_periph_out), .pp_periph_in(pp_periph_in),
        .dp_pin_in(dp_pin_in), .dp_pin_out(dp_pin_out), .dp_pin_oe(dp_pin_oe), .dp_seg_drive(dp_seg_drive),
        .ext_interrupt_pin(ext_interrupt_pin), .serial_prog_pins(serial_prog_pins),
        .port_change_irq(port_change_irq), .wake_request(wake_request));
    kpio_pin_model pins (.clock(clock), .kp_pin_out(kp_pin_out), .kp_pin_oe(kp_pin_oe),
        .kp_pullup_en(kp_pullup_en), .key_down(key_down), .kp_pin_in(kp_pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // request held until waitrequest is seen low, released right after that edge
    task automatic bus(input logic is_wr, input logic [8:0] idx, input logic [15:0] d, input logic [3:0] be);
        @(posedge clock);
        avs_read <= ~is_wr;
        avs_write <= is_wr;
        avs_address <= {idx, 2'h0};
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        @(posedge clock);
        while (avs_waitrequest) @(posedge clock);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic wr(input logic [8:0] idx, input logic [15:0] d);
        bus(1'h1, idx, d, 4'hF);
    endtask
    task automatic rd(input logic [8:0] idx, input logic [7:0] e, input logic [7:0] k);
        exp_q.push_back(e & k);
        msk_q.push_back(k);
        bus(1'h0, idx, 16'h0000, 4'hF);
    endtask
    // outputs lag their register by one clock, so wait n rising edges, then look at the falling edge
    task automatic pause(input integer n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        test_done;
    end
    // read data is loaded at the answer edge: compare once it has settled
    always @(posedge clock) begin
        if (avs_read && !avs_waitrequest) begin
            @(negedge clock);
            m = msk_q.pop_front();
            chk("readdata", exp_q.pop_front(), avs_readdata[7:0] & m);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        pause(1);
        chk("pullups", 8'h00, kp_pullup_en);
        chk("seg_drive", 8'hFF, dp_seg_drive);
        foreach (ridx[k]) rd(ridx[k], rval[k], 8'hFF);
        bus(1'h1, `KPIO_IDX_OPTION, 16'h007F, 4'h0);
        rd(`KPIO_IDX_OPTION, 8'hFF, 8'hFF);
        wr(`KPIO_IDX_OPTION, 16'h007F);
        wr(`KPIO_IDX_KEYPAD_DIR, 16'h000F);
        r = $random(seed);
        wr(`KPIO_IDX_KEYPAD_DATA, {8'h00, r});
        pause(2);
        chk("pullups", 8'h0F, kp_pullup_en);
        chk("kp_oe", 8'hF0, kp_pin_oe);
        chk("kp_out", r, kp_pin_out);
        wr(`KPIO_IDX_KEYPAD_DIR, 16'h00FF);
        rd(`KPIO_IDX_KEYPAD_DATA, 8'hFF, 8'hFF);
        wr(`KPIO_IDX_INTCTRL, 16'h0000);
        @(posedge clock);
        key_down <= 8'h02;
        pause(3);
        chk("irq", 8'h00, {7'h00, port_change_irq});
        @(posedge clock);
        key_down <= 8'h22;
        pause(3);
        chk("irq", 8'h01, {7'h00, port_change_irq});
        chk("wake", 8'h01, {7'h00, wake_request});
        wr(`KPIO_IDX_INTCTRL, 16'h0000);
        rd(`KPIO_IDX_INTCTRL, 8'h01, 8'h01);
        rd(`KPIO_IDX_KEYPAD_DATA, 8'hDD, 8'hFF);
        wr(`KPIO_IDX_INTCTRL, 16'h0000);
        rd(`KPIO_IDX_INTCTRL, 8'h00, 8'h01);
        wr(`KPIO_IDX_KEYPAD_DATA, 16'h0000);
        wr(`KPIO_IDX_KEYPAD_DIR, 16'h007F);
        pause(3);
        chk("irq", 8'h00, {7'h00, port_change_irq});
        wr(`KPIO_IDX_MODE, 16'h0003);
        pause(2);
        chk("ser_prog", 8'h01, {6'h00, serial_prog_pins});
        chk("ext_int", 8'h01, {7'h00, ext_interrupt_pin});
        // press and release key 0: the rising edge must raise the external flag
        @(posedge clock);
        key_down <= 8'h23;
        pause(1);
        @(posedge clock);
        key_down <= 8'h22;
        pause(2);
        rd(`KPIO_IDX_INTCTRL, 8'h02, 8'h02);
        r = $random(seed);
        @(posedge clock);
        pp_periph_out <= r[5:0];
        pp_pin_in <= r[7:2];
        dp_pin_in <= ~r;
        wr(`KPIO_IDX_PERIPH_DIR, {10'h000, r[5:0]});
        wr(`KPIO_IDX_PERIPH_OVR, 16'h0004);
        wr(`KPIO_IDX_PERIPH_DATA, {10'h000, ~r[5:0]});
        pause(2);
        chk("pp_oe", {2'h0, ~r[5:3], 1'h1, ~r[1:0]}, {2'h0, pp_pin_oe});
        chk("pp_out", {2'h0, ~r[5:3], r[2], ~r[1:0]}, {2'h0, pp_pin_out});
        chk("pp_in", {2'h0, r[7:2]}, {2'h0, pp_periph_in});
        rd(`KPIO_IDX_PERIPH_DATA, {2'h0, r[7:2]}, 8'h3F);
        wr(`KPIO_IDX_DISPLAY_DIR, {8'h00, r});
        wr(`KPIO_IDX_DISPLAY_DATA, {8'h00, ~r});
        rd(`KPIO_IDX_DISPLAY_DATA, ~r, 8'hFF);
        for (i = 0; i < 4; i++) begin
            wr(`KPIO_IDX_SEGEN, {8'h00, i[1], 6'h00, i[0]});
            pause(2);
            chk("seg_drive", {{3{i[1]}}, {5{i[0]}}}, dp_seg_drive);
            chk("dp_oe", {3'h0, ~r[4:0] & {5{!i[0]}}}, dp_pin_oe);
            chk("dp_out", ~r, dp_pin_out);
        end
        @(posedge clock);
        reset_n <= 1'h0;
        pause(2);
        @(posedge clock);
        reset_n <= 1'h1;
        pause(1);
        chk("pullups", 8'h00, kp_pullup_en);
        chk("seg_drive", 8'hFF, dp_seg_drive);
        test_done;
    end
endmodule // tb_keypad_io_ports_b_c_d
`default_nettype wire
